// ==== rtl/pll_div_consts.svh ====
`ifndef PLL_DIV_CONSTS_SVH
`define PLL_DIV_CONSTS_SVH

// address byte, first received bit in bit 0
`define ADDR_IN_DIVIDER     8'h28
`define ADDR_IN_OUTPUT_SEL  8'h29
`define ADDR_OUT_READBACK   8'h2A

`define FRAME_BITS          5'h18

// divider-settings frame fields
`define FLD_DIVISOR_LSB     0
`define FLD_BAND_SEL        16
`define FLD_DIV_MODE        17
// output-select frame field
`define FLD_OUT_SEL_LSB     0

`define SWALLOW_MIN         16'h0110
`define SWALLOW_MAX         16'hFFFF
`define DIRECT_MIN          16'h0004
`define DIRECT_MAX          16'h0FFF

`define RST_DIVISOR         16'h0110
`define RST_BAND_SEL        1'h0
`define RST_DIV_MODE        1'h1
`define RST_OUT_SEL         3'h0

`define OUT_SEL_SETTINGS    3'h0
`define OUT_SEL_COUNT       3'h1

`endif

// ==== rtl/pll_div_pkg.sv ====
package pll_div_pkg;
	typedef enum logic [2:0] {
		SER_ADDR     = 3'h0,
		SER_IN_DIV   = 3'h1,
		SER_IN_OSEL  = 3'h2,
		SER_OUT      = 3'h3,
		SER_SKIP     = 3'h4
	} ser_state_e;
endpackage

// ==== rtl/pll_divider_input_select.sv ====
`include "pll_div_consts.svh"
// Behaviour
// R1: band select 1 sends the high-band input through a divide-by-two prescaler into the swallow counter.
// R2: high-band settings 272 to 65535 are accepted and the overall ratio is twice the setting.
// R3: band select 0 takes the divider input from the low-band input.
// R4: low band with divide mode 1 feeds the swallow counter directly, settings 272 to 65535, ratio equals setting.
// R5: low band with divide mode 0 feeds a 12-bit direct divider, settings 4 to 4095, ratio equals setting.
// R6: the controller holds chip enable high for the whole of every data transfer.
// R7: the serial clock from the controller times both sampled input bits and shifted output bits.
// R8: the serial data input line is the only path for control settings.
// R9: the data output line carries content chosen by a three-bit output-select field.
// R10: a power-on reset puts all control settings in their initial state before programming.
// R11: each transfer starts with an 8-bit address byte selecting write or read-back.
// R12: new divider settings take effect only when a complete input transfer has ended.
module pll_divider_input_select (
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic        chip_enable_in,
	input  wire logic        serial_clock_line_in,
	input  wire logic        serial_in_line_in,
	input  wire logic        high_band_osc_input_in,
	input  wire logic        low_band_osc_input_in,
	output logic             serial_out_line_out,
	output logic             serial_out_oe_n_out,
	output logic             band_input_select_out,
	output logic             low_band_divide_mode_out,
	output logic [15:0]      divisor_out,
	output logic [2:0]       output_content_select_out,
	output logic             divided_pulse_out
);
	localparam int IX_CE   = 0;
	localparam int IX_SCLK = 1;
	localparam int IX_SDI  = 2;
	localparam int IX_HB   = 3;
	localparam int IX_LB   = 4;

	function automatic logic divisor_ok(input logic [15:0] d, input logic band, input logic mode);
		if (band || mode)
			divisor_ok = (d >= `SWALLOW_MIN) && (d <= `SWALLOW_MAX);
		else
			divisor_ok = (d >= `DIRECT_MIN) && (d <= `DIRECT_MAX);
	endfunction

	// input synchronisers: stage 1 feeds stage 2 only
	logic [4:0] sync1_r;
	logic [4:0] sync2_r;
	logic [4:0] prev_r;
	logic       ce_rise;
	logic       ce_fall;
	logic       sclk_rise;
	logic       sclk_fall;
	logic       hb_rise;
	logic       lb_rise;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			sync1_r <= 5'h00;
			sync2_r <= 5'h00;
			prev_r  <= 5'h00;
		end else begin
			sync1_r <= {low_band_osc_input_in, high_band_osc_input_in, serial_in_line_in,
			            serial_clock_line_in, chip_enable_in};
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	always_comb begin
		ce_rise   = sync2_r[IX_CE] & ~prev_r[IX_CE];
		ce_fall   = ~sync2_r[IX_CE] & prev_r[IX_CE];
		sclk_rise = sync2_r[IX_SCLK] & ~prev_r[IX_SCLK];
		sclk_fall = ~sync2_r[IX_SCLK] & prev_r[IX_SCLK];
		hb_rise   = sync2_r[IX_HB] & ~prev_r[IX_HB];
		lb_rise   = sync2_r[IX_LB] & ~prev_r[IX_LB];
	end

	// serial port and active settings
	pll_div_pkg::ser_state_e state_r, state_nxt;
	logic [7:0]  addr_r, addr_nxt;
	logic [23:0] shift_r, shift_nxt;
	logic [4:0]  bit_cnt_r, bit_cnt_nxt;
	logic [23:0] out_word_r, out_word_nxt;
	logic        sdo_r, sdo_nxt;
	logic        oe_n_r, oe_n_nxt;
	logic [15:0] divisor_r, divisor_nxt;
	logic        band_r, band_nxt;
	logic        mode_r, mode_nxt;
	logic [2:0]  osel_r, osel_nxt;
	logic        applied_nxt;
	logic [15:0] count_r, count_nxt;
	logic        presc_r, presc_nxt;
	logic        pulse_r, pulse_nxt;

	always_comb begin
		state_nxt    = state_r;
		addr_nxt     = addr_r;
		shift_nxt    = shift_r;
		bit_cnt_nxt  = bit_cnt_r;
		out_word_nxt = out_word_r;
		sdo_nxt      = sdo_r;
		oe_n_nxt     = oe_n_r;
		divisor_nxt  = divisor_r;
		band_nxt     = band_r;
		mode_nxt     = mode_r;
		osel_nxt     = osel_r;
		applied_nxt  = 1'h0;
		case (state_r)
			pll_div_pkg::SER_ADDR: begin
				// R11: address byte clocked in while enable is low
				if (sclk_rise && !sync2_r[IX_CE])
					addr_nxt = {sync2_r[IX_SDI], addr_r[7:1]};
				if (ce_rise) begin
					bit_cnt_nxt = 5'h00;
					shift_nxt   = 24'h000000;
					case (addr_r)
						`ADDR_IN_DIVIDER:    state_nxt = pll_div_pkg::SER_IN_DIV;
						`ADDR_IN_OUTPUT_SEL: state_nxt = pll_div_pkg::SER_IN_OSEL;
						`ADDR_OUT_READBACK: begin
							// R9: read-back word picked by output select
							state_nxt = pll_div_pkg::SER_OUT;
							case (osel_r)
								`OUT_SEL_SETTINGS: out_word_nxt = {6'h00, mode_r, band_r, divisor_r};
								`OUT_SEL_COUNT:    out_word_nxt = {8'h00, count_r};
								default:           out_word_nxt = 24'h000000;
							endcase
						end
						default:             state_nxt = pll_div_pkg::SER_SKIP;
					endcase
				end
			end
			pll_div_pkg::SER_IN_DIV, pll_div_pkg::SER_IN_OSEL: begin
				// R7: data sampled on serial clock rising edge
				// R8: settings arrive only on the serial input
				if (sclk_rise) begin
					shift_nxt = {sync2_r[IX_SDI], shift_r[23:1]};
					if (bit_cnt_r != 5'h1F)
						bit_cnt_nxt = bit_cnt_r + 5'h01;
				end
				// R6: transfer closes when enable drops
				if (ce_fall) begin
					state_nxt = pll_div_pkg::SER_ADDR;
					addr_nxt  = 8'h00;
					// R12: only a whole frame changes the settings
					if (bit_cnt_r == `FRAME_BITS) begin
						if (state_r == pll_div_pkg::SER_IN_OSEL) begin
							osel_nxt = shift_r[`FLD_OUT_SEL_LSB +: 3];
						end else if (divisor_ok(shift_r[`FLD_DIVISOR_LSB +: 16], shift_r[`FLD_BAND_SEL],
						                        shift_r[`FLD_DIV_MODE])) begin
							// R2: out-of-range divisors leave the old setting active
							divisor_nxt = shift_r[`FLD_DIVISOR_LSB +: 16];
							band_nxt    = shift_r[`FLD_BAND_SEL];
							mode_nxt    = shift_r[`FLD_DIV_MODE];
							applied_nxt = 1'h1;
						end
					end
				end
			end
			pll_div_pkg::SER_OUT: begin
				oe_n_nxt = 1'h0;
				sdo_nxt  = out_word_r[0];
				// R7: next output bit after each falling serial clock
				if (sclk_fall)
					out_word_nxt = {1'h0, out_word_r[23:1]};
				if (ce_fall) begin
					state_nxt = pll_div_pkg::SER_ADDR;
					addr_nxt  = 8'h00;
					oe_n_nxt  = 1'h1;
					sdo_nxt   = 1'h0;
				end
			end
			pll_div_pkg::SER_SKIP: begin
				if (ce_fall) begin
					state_nxt = pll_div_pkg::SER_ADDR;
					addr_nxt  = 8'h00;
				end
			end
			default: state_nxt = pll_div_pkg::SER_ADDR;
		endcase
	end

	// divider datapath
	always_comb begin
		logic tick;
		tick      = 1'h0;
		presc_nxt = presc_r;
		count_nxt = count_r;
		pulse_nxt = 1'h0;
		if (band_r) begin
			// R1: high band passes the divide-by-two prescaler first
			if (hb_rise) begin
				presc_nxt = ~presc_r;
				tick      = presc_r;
			end
		end else begin
			// R3: low band input chosen
			tick = lb_rise;
		end
		if (applied_nxt) begin
			count_nxt = 16'h0000;
			presc_nxt = 1'h0;
		end else if (tick) begin
			// R4: swallow path counts full 16 bits
			// R5: direct path uses only the 12-bit setting
			if ((band_r || mode_r) ? (count_r >= divisor_r - 16'h0001)
			                       : (count_r[11:0] >= divisor_r[11:0] - 12'h001)) begin
				count_nxt = 16'h0000;
				pulse_nxt = 1'h1;
			end else begin
				count_nxt = count_r + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		// R10: reset places settings in their initial state
		if (sys_rst_in) begin
			state_r    <= pll_div_pkg::SER_ADDR;
			addr_r     <= 8'h00;
			shift_r    <= 24'h000000;
			bit_cnt_r  <= 5'h00;
			out_word_r <= 24'h000000;
			sdo_r      <= 1'h0;
			oe_n_r     <= 1'h1;
			divisor_r  <= `RST_DIVISOR;
			band_r     <= `RST_BAND_SEL;
			mode_r     <= `RST_DIV_MODE;
			osel_r     <= `RST_OUT_SEL;
			count_r    <= 16'h0000;
			presc_r    <= 1'h0;
			pulse_r    <= 1'h0;
		end else begin
			state_r    <= state_nxt;
			addr_r     <= addr_nxt;
			shift_r    <= shift_nxt;
			bit_cnt_r  <= bit_cnt_nxt;
			out_word_r <= out_word_nxt;
			sdo_r      <= sdo_nxt;
			oe_n_r     <= oe_n_nxt;
			divisor_r  <= divisor_nxt;
			band_r     <= band_nxt;
			mode_r     <= mode_nxt;
			osel_r     <= osel_nxt;
			count_r    <= count_nxt;
			presc_r    <= presc_nxt;
			pulse_r    <= pulse_nxt;
		end
	end

	always_comb begin
		serial_out_line_out       = sdo_r;
		serial_out_oe_n_out       = oe_n_r;
		band_input_select_out     = band_r;
		low_band_divide_mode_out  = mode_r;
		divisor_out               = divisor_r;
		output_content_select_out = osel_r;
		divided_pulse_out         = pulse_r;
	end
endmodule

// ==== tb/pll_div_checker.sv ====
`include "pll_div_consts.svh"
module pll_div_checker (
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	input  wire logic        chip_enable_in,
	input  wire logic        serial_out_line_out,
	input  wire logic        serial_out_oe_n_out,
	input  wire logic        band_input_select_out,
	input  wire logic        low_band_divide_mode_out,
	input  wire logic [15:0] divisor_out,
	input  wire logic [2:0]  output_content_select_out,
	input  wire logic        divided_pulse_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0]  ce_low_r;
	logic [3:0]  ce_low_nxt;
	logic [20:0] cfg;
	assign cfg = {band_input_select_out, low_band_divide_mode_out, divisor_out, output_content_select_out};
	// saturates so a long idle gap never wraps back into the driving window
	always_comb begin
		ce_low_nxt = ce_low_r;
		if (chip_enable_in)
			ce_low_nxt = 4'h0;
		else if (ce_low_r != 4'hF)
			ce_low_nxt = ce_low_r + 4'h1;
	end
	always_ff @(posedge clk_in) begin
		ce_low_r <= sys_rst_in ? 4'hF : ce_low_nxt;
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	sequence ce_drop;
		chip_enable_in ##1 !chip_enable_in;
	endsequence
	reset_vals_a: assert property (
		$fell(sys_rst_in) |-> cfg == {`RST_BAND_SEL, `RST_DIV_MODE, `RST_DIVISOR, `RST_OUT_SEL})
		else $error("bad reset state");
	swallow_rng_a: assert property (
		(band_input_select_out || low_band_divide_mode_out) |-> divisor_out >= `SWALLOW_MIN)
		else $error("swallow divisor out of range");
	direct_rng_a: assert property (
		(!band_input_select_out && !low_band_divide_mode_out) |-> divisor_out inside {[`DIRECT_MIN:`DIRECT_MAX]})
		else $error("direct divisor out of range");
	update_on_drop_a: assert property (
		!$stable(cfg) |-> !chip_enable_in && ($past(chip_enable_in, 3) || $past(chip_enable_in, 4)
		|| $past(chip_enable_in, 5) || $past(chip_enable_in, 6))) else $error("settings moved mid frame");
	hold_drop_a: assert property (
		ce_drop |=> $stable(cfg) [*2]) else $error("settings moved too early");
	idle_low_a: assert property (
		serial_out_oe_n_out |-> !serial_out_line_out) else $error("data out not low when idle");
	drive_frame_a: assert property (
		!serial_out_oe_n_out |-> ce_low_r < 4'h8) else $error("data out driven outside frame");
	pulse_gap_a: assert property (
		divided_pulse_out |=> !divided_pulse_out [*6]) else $error("divider pulses too close");
endmodule

bind pll_divider_input_select pll_div_checker chk (
	.clk_in(clk_in), .sys_rst_in(sys_rst_in), .chip_enable_in(chip_enable_in),
	.serial_out_line_out(serial_out_line_out), .serial_out_oe_n_out(serial_out_oe_n_out),
	.band_input_select_out(band_input_select_out), .low_band_divide_mode_out(low_band_divide_mode_out),
	.divisor_out(divisor_out), .output_content_select_out(output_content_select_out),
	.divided_pulse_out(divided_pulse_out)
);

// ==== tb/ser_ctl_model.sv ====
module ser_ctl_model (
	input  wire logic clk_in,
	input  wire logic serial_out_line_in,
	input  wire logic serial_out_oe_n_in,
	output logic      chip_enable_out,
	output logic      serial_clock_line_out,
	output logic      serial_in_line_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic line_lvl;
	// open-drain return line with pull-up
	assign line_lvl = serial_out_oe_n_in | serial_out_line_in;
	initial begin
		chip_enable_out = 1'b0;
		serial_clock_line_out = 1'b0;
		serial_in_line_out = 1'b0;
	end
	task automatic half();
		repeat (10) @(posedge clk_in);
	endtask
	task automatic bit_cyc(input logic b, output logic q);
		serial_in_line_out <= b;
		half();
		serial_clock_line_out <= 1'b1;
		q = line_lvl;
		half();
		serial_clock_line_out <= 1'b0;
	endtask
	task automatic xfer(input logic [7:0] adr, input logic [23:0] dat, input int n, output logic [23:0] rd);
		logic q;
		rd = 24'h0;
		for (int i = 0; i < 8; i++)
			bit_cyc(adr[i], q);
		half();
		chip_enable_out <= 1'b1;
		half();
		for (int i = 0; i < n; i++) begin
			bit_cyc(dat[i], q);
			rd[i] = q;
		end
		half();
		chip_enable_out <= 1'b0;
		serial_in_line_out <= ~serial_in_line_out;
		half();
		half();
	endtask
endmodule

// ==== tb/tb_pll_divider_input_select.sv ====
module tb_pll_divider_input_select;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_in     = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic [3:0]  osc_cnt    = 4'h0;
	logic        chip_enable, serial_clock_line, serial_in_line, sdo, oe_n, band, mode, pulse;
	logic [15:0] divisor;
	logic [2:0]  sel;
	logic [23:0] rd;
	logic [23:0] cur;
	int          error_cnt  = 0;
	int          n_checks   = 0;
	assign cur = {6'h00, mode, band, divisor};
	always #2 clk_in = ~clk_in;
	// high band at four times the low band rate: through the prescaler it still ticks twice as fast,
	// so a wrong input or a missing prescaler shows in the pulse spacing
	always @(posedge clk_in) osc_cnt <= osc_cnt + 4'h1;
	pll_divider_input_select uut (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .chip_enable_in(chip_enable),
		.serial_clock_line_in(serial_clock_line), .serial_in_line_in(serial_in_line),
		.high_band_osc_input_in(osc_cnt[1]), .low_band_osc_input_in(osc_cnt[3]),
		.serial_out_line_out(sdo), .serial_out_oe_n_out(oe_n), .band_input_select_out(band),
		.low_band_divide_mode_out(mode), .divisor_out(divisor), .output_content_select_out(sel),
		.divided_pulse_out(pulse)
	);
	ser_ctl_model ctl (
		.clk_in(clk_in), .serial_out_line_in(sdo), .serial_out_oe_n_in(oe_n),
		.chip_enable_out(chip_enable), .serial_clock_line_out(serial_clock_line),
		.serial_in_line_out(serial_in_line)
	);
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic per(input int exp);
		int c;
		// look at the pulse mid-cycle, away from the edge that launches it
		@(negedge clk_in);
		while (pulse !== 1'b1)
			@(negedge clk_in);
		@(negedge clk_in);
		c = 1;
		while (pulse !== 1'b1 && c < 70000) begin
			@(negedge clk_in);
			c++;
		end
		chk(24'(c), 24'(exp));
		@(posedge clk_in);
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		repeat (5) @(posedge clk_in);
		chk(cur, 24'h020110);
		per(4352);
		ctl.xfer(8'h28, 24'h01012C, 24, rd);
		chk(cur, 24'h01012C);
		per(2400);
		ctl.xfer(8'h28, 24'h000004, 24, rd);
		chk(cur, 24'h000004);
		per(64);
		ctl.xfer(8'h28, 24'h001000, 24, rd);
		ctl.xfer(8'h28, 24'h02010F, 24, rd);
		ctl.xfer(8'h33, 24'h020200, 24, rd);
		ctl.xfer(8'h28, 24'h000FFF, 23, rd);
		chk(cur, 24'h000004);
		ctl.xfer(8'h28, 24'h000FFF, 24, rd);
		chk(cur, 24'h000FFF);
		ctl.xfer(8'h29, 24'h000001, 24, rd);
		chk({21'h0, sel}, 24'h000001);
		ctl.xfer(8'h2A, 24'h000000, 24, rd);
		chk({23'h0, rd < 24'h000FFF}, 24'h000001);
		ctl.xfer(8'h29, 24'h000002, 24, rd);
		ctl.xfer(8'h2A, 24'h000000, 24, rd);
		chk(rd, 24'h000000);
		ctl.xfer(8'h29, 24'h000000, 24, rd);
		ctl.xfer(8'h2A, 24'h000000, 24, rd);
		chk(rd, 24'h000FFF);
		conclude();
	end
	initial begin
		#320000;
		error_cnt++;
		conclude();
	end
endmodule
